// ===== hw/tcm_regs.svh
`ifndef TCM_REGS_SVH
`define TCM_REGS_SVH

// Symbol and trellis geometry
`define TCM_SOFTBITS 4
`define TCM_CODED_BITS 2
`define TCM_STATE_BITS 2
`define TCM_END_STATE_BITS 4

// Register byte offsets
`define TCM_OFF_CTRL 8'h00
`define TCM_OFF_POLY 8'h04
`define TCM_OFF_STATUS 8'h08
`define TCM_OFF_NUMERR 8'h0C

// Control register fields and reset value
`define TCM_CTRL_CONT 0
`define TCM_CTRL_KIND 1
`define TCM_CTRL_RESET 32'h0000_0002

// Polynomial register fields and reset value
`define TCM_POLY_FIRST_LSB 0
`define TCM_POLY_SECOND_LSB 8
`define TCM_POLY_RESET 32'h0000_0507

// Status register fields
`define TCM_STATUS_PHASE_LSB 0
`define TCM_STATUS_LEN_LSB 8

// Bus timing: zero wait states, answer in the access cycle
`define TCM_APB_WAIT 0

`endif

// ===== hw/tcm_pkg.sv
`include "tcm_regs.svh"

package tcm_pkg;

  // One branch metric, softbits wide
  typedef logic [`TCM_SOFTBITS-1:0] tcm_bm_type;

  // Four branch metrics, bm3 in the top field, no padding
  typedef struct packed {
    tcm_bm_type bm3;
    tcm_bm_type bm2;
    tcm_bm_type bm1;
    tcm_bm_type bm0;
  } tcm_symbol_type;

  // Sequencer phase
  typedef enum logic [1:0] {
    TCM_RUN,
    TCM_TRACE,
    TCM_EMIT
  } tcm_phase_type;

endpackage

// ===== hw/tcm_acs.sv
`include "tcm_regs.svh"

module tcm_acs #(
  parameter int MW = 12
) (
  // Survivor metrics before this symbol
  input wire logic [3:0][MW-1:0] metric_in,
  // Four branch metrics of this symbol
  input wire tcm_pkg::tcm_symbol_type soft_symbol_in,
  // Generator polynomials, input tap at the MSB
  input wire logic [2:0] poly_first,
  input wire logic [2:0] poly_second,
  // Updated metrics and one survivor choice per state
  output logic [3:0][MW-1:0] metric_out,
  output logic [3:0] decision
);
  localparam int SB = `TCM_SOFTBITS;

  // Branch metrics as an array indexed by the coded pair
  wire [3:0][SB-1:0] bm_arr = soft_symbol_in;
  wire [3:0][MW-1:0] survivor;
  wire [3:0] msb;
  // Clear all MSBs together; differences between states survive
  wire renorm = &msb;

  // Coded pair of one branch, high bit from the first polynomial
  function automatic logic [1:0] code_of(input logic [2:0] taps, input logic [2:0] pf,
                                         input logic [2:0] ps);
    code_of = {^(taps & pf), ^(taps & ps)};
  endfunction

  // Saturating add, so a metric parked at the top cannot wrap to a low value
  function automatic logic [MW-1:0] grow(input logic [MW-1:0] m, input logic [SB-1:0] bm);
    logic [MW:0] sum;
    sum = {1'b0, m} + {{(MW+1-SB){1'b0}}, bm};
    grow = sum[MW] ? {MW{1'b1}} : sum[MW-1:0];
  endfunction

  // One add-compare-select per next state; newest bit enters at the MSB
  genvar ns;
  generate
    for (ns = 0; ns < 4; ns++) begin : g_state
      localparam logic [1:0] NS = 2'(ns);
      localparam logic [1:0] PRED0 = {NS[0], 1'b0};
      localparam logic [1:0] PRED1 = {NS[0], 1'b1};
      // Two predecessors, each branch a pair of parallel paths in one subset
      wire [1:0] idx0 = code_of({NS[1], PRED0}, poly_first, poly_second);
      wire [1:0] idx1 = code_of({NS[1], PRED1}, poly_first, poly_second);
      wire [MW-1:0] cand0 = grow(metric_in[PRED0], bm_arr[idx0]);
      wire [MW-1:0] cand1 = grow(metric_in[PRED1], bm_arr[idx1]);
      // Larger accumulated metric is the more likely path
      assign decision[ns] = cand1 > cand0;
      assign survivor[ns] = decision[ns] ? cand1 : cand0;
      assign msb[ns] = survivor[ns][MW-1];
      assign metric_out[ns] = renorm ? {1'b0, survivor[ns][MW-2:0]} : survivor[ns];
    end
  endgenerate

endmodule

// ===== hw/tcm_trellis_decoder.sv
// What this block does
// - Trellis mode decodes rate one half only
// - Four states, parallel paths per transition
// - Metric three top field, metric zero bottom
// - Error count meaningless, reads as zero
// - End state is tail bits reversed
// - Parallel variant always starts in state zero
// - Hybrid start state spans all states
// - Hybrid start: chosen state value, others zero
// - Continuous mode keeps metrics across blocks
// - Reset: state zero zero, others maximum
// - End of packet: trace back from end state
// - End state four bits, upper bits ignored
//
// Our own choices: the address map and the APB slave port.
`include "tcm_regs.svh"

module tcm_trellis_decoder #(
  parameter int MW = 12,
  parameter int DEPTH = 64,
  parameter bit HYBRID = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Symbol input stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire tcm_pkg::tcm_symbol_type soft_symbol_in,
  // Per-block state settings
  input wire logic [`TCM_END_STATE_BITS-1:0] traceback_end_state,
  input wire logic [`TCM_END_STATE_BITS-1:0] metric_start_state,
  input wire logic [MW-1:0] metric_start_value,
  // Decoded bit stream
  output logic out_valid,
  input wire logic out_ready,
  output logic out_bit,
  output logic out_eop,
  // Error estimate, constant in this mode
  output logic [7:0] numerr
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);
  // Start value for the fixed-start variant, a quarter of the way up the metric range
  localparam logic [MW-1:0] INIT_VALUE = {2'b01, {(MW-2){1'b0}}};
  localparam logic [MW-1:0] METRIC_MAX = {MW{1'b1}};

  // Control and polynomial registers
  logic continuous; // Metrics carry over between blocks
  logic tb_kind; // 1: end state input, 0: best state
  logic [2:0] poly_first; // Tap set for the high coded bit
  logic [2:0] poly_second; // Tap set for the low coded bit

  // Decoder state
  tcm_pkg::tcm_phase_type phase;
  logic [3:0][MW-1:0] metric; // Survivor metrics
  logic [3:0] dec_mem [DEPTH]; // Survivor choices per symbol
  logic [DEPTH-1:0] obuf; // Decoded bits awaiting output
  logic [PW-1:0] fill; // Next free slot
  logic [PW-1:0] last_idx; // Slot of the block's final symbol
  logic [PW-1:0] rptr; // Traceback position
  logic [PW-1:0] optr; // Output position
  logic [1:0] tb_state; // Current traceback state
  logic [1:0] best_state; // Highest metric after this symbol
  logic first_cycle; // Helper for the reset check

  // ACS connections
  wire [3:0][MW-1:0] init_vec;
  wire [3:0][MW-1:0] base_metric;
  wire [3:0][MW-1:0] next_metric;
  wire [3:0] decision;

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire hit_ctrl = paddr == `TCM_OFF_CTRL;
  wire hit_poly = paddr == `TCM_OFF_POLY;
  wire hit_status = paddr == `TCM_OFF_STATUS;
  wire hit_numerr = paddr == `TCM_OFF_NUMERR;
  wire mapped = hit_ctrl || hit_poly || hit_status || hit_numerr;
  wire apb_wr_ctrl = apb_access && pwrite && hit_ctrl;
  wire apb_wr_poly = apb_access && pwrite && hit_poly;

  // Read words
  wire [31:0] ctrl_word = (32'(tb_kind) << `TCM_CTRL_KIND) | (32'(continuous) << `TCM_CTRL_CONT);
  wire [31:0] poly_word = (32'(poly_second) << `TCM_POLY_SECOND_LSB)
                        | (32'(poly_first) << `TCM_POLY_FIRST_LSB);
  wire [31:0] status_word = (32'(last_idx) << `TCM_STATUS_LEN_LSB)
                          | (32'(phase) << `TCM_STATUS_PHASE_LSB);
  // Error count has no meaning here, so it reads as zero
  wire [31:0] read_word = hit_ctrl ? ctrl_word :
                          hit_poly ? poly_word :
                          hit_status ? status_word : 32'h0000_0000;

  // No wait states; unmapped access gets an error and writes nothing
  assign pready = 1'b1;
  assign pslverr = apb_access && !mapped;
  assign numerr = 8'h00;

  // Stream handshakes
  wire accept = in_valid && in_ready;
  wire [PW-1:0] slot = in_sop ? '0 : fill;
  // A full store ends the block just as an end of packet does
  wire block_end = accept && (in_eop || slot == LAST_SLOT);
  // Only the low state bits matter for four states
  wire [1:0] end_state = traceback_end_state[`TCM_STATE_BITS-1:0];
  wire [3:0] tb_dec = dec_mem[rptr];
  wire [1:0] tb_pred = {tb_state[0], tb_dec[tb_state]};
  wire out_fire = out_valid && out_ready;

  assign in_ready = phase == tcm_pkg::TCM_RUN;
  assign out_valid = phase == tcm_pkg::TCM_EMIT;
  assign out_eop = out_valid && optr == last_idx;
  // Output bit is a select over the flop buffer
  assign out_bit = obuf[optr];

  // Block-start metrics: chosen state gets the value (state zero gets INIT_VALUE without HYBRID), others zero
  genvar s;
  generate
    for (s = 0; s < 4; s++) begin : g_init
      if (HYBRID) begin : g_hyb
        assign init_vec[s] = metric_start_state[`TCM_STATE_BITS-1:0] == 2'(s) ?
                             metric_start_value : '0;
      end else begin : g_par
        assign init_vec[s] = s == 0 ? INIT_VALUE : '0;
      end
    end
  endgenerate

  // Continuous mode never reloads; block mode reloads on start of packet
  assign base_metric = (in_sop && !continuous) ? init_vec : metric;

  // Rate one half trellis update
  tcm_acs #(
    .MW(MW)
  ) u_acs (
    .metric_in(base_metric),
    .soft_symbol_in(soft_symbol_in),
    .poly_first(poly_first),
    .poly_second(poly_second),
    .metric_out(next_metric),
    .decision(decision)
  );

  // Best survivor, used when no end state is known
  always_comb begin
    best_state = 2'h0;
    for (int i = 1; i < 4; i++) begin
      if (next_metric[i] > next_metric[best_state]) begin
        best_state = 2'(i);
      end
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      continuous <= 1'(`TCM_CTRL_RESET >> `TCM_CTRL_CONT);
      tb_kind <= 1'(`TCM_CTRL_RESET >> `TCM_CTRL_KIND);
      poly_first <= 3'(`TCM_POLY_RESET >> `TCM_POLY_FIRST_LSB);
      poly_second <= 3'(`TCM_POLY_RESET >> `TCM_POLY_SECOND_LSB);
    end else begin
      if (apb_wr_ctrl) begin
        continuous <= pwdata[`TCM_CTRL_CONT];
        tb_kind <= pwdata[`TCM_CTRL_KIND];
      end
      if (apb_wr_poly) begin
        poly_first <= pwdata[`TCM_POLY_FIRST_LSB +: 3];
        poly_second <= pwdata[`TCM_POLY_SECOND_LSB +: 3];
      end
    end
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= read_word;
    end
  end

  // Metrics: state zero at zero, the rest parked at the top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      metric <= {METRIC_MAX, METRIC_MAX, METRIC_MAX, {MW{1'b0}}};
    end else if (accept) begin
      metric <= next_metric;
    end
  end

  // Survivor memory, no reset needed: every slot is written before read
  always_ff @(posedge pclk) begin
    if (accept) begin
      dec_mem[slot] <= decision;
    end
  end

  // Decoded bits land in reverse order during traceback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obuf <= '0;
    end else if (phase == tcm_pkg::TCM_TRACE) begin
      obuf[rptr] <= tb_state[1];
    end
  end

  // Sequencer: run, trace back, emit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= tcm_pkg::TCM_RUN;
      fill <= '0;
      last_idx <= '0;
      rptr <= '0;
      optr <= '0;
      tb_state <= 2'h0;
    end else begin
      unique case (phase)
        tcm_pkg::TCM_RUN: begin
          if (accept) begin
            fill <= slot + PW'(1);
          end
          // Switch to block traceback at end of packet or when the store is full
          if (block_end) begin
            phase <= tcm_pkg::TCM_TRACE;
            last_idx <= slot;
            rptr <= slot;
            tb_state <= tb_kind ? end_state : best_state;
          end
        end
        tcm_pkg::TCM_TRACE: begin
          tb_state <= tb_pred;
          if (rptr == '0) begin
            phase <= tcm_pkg::TCM_EMIT;
            optr <= '0;
          end else begin
            rptr <= rptr - PW'(1);
          end
        end
        tcm_pkg::TCM_EMIT: begin
          if (out_fire) begin
            if (out_eop) begin
              phase <= tcm_pkg::TCM_RUN;
              fill <= '0;
            end else begin
              optr <= optr + PW'(1);
            end
          end
        end
      endcase
    end
  end

  // Marks the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_block_end;
    block_end && phase == tcm_pkg::TCM_RUN;
  endsequence

  sequence s_trace_done;
    phase == tcm_pkg::TCM_TRACE && rptr == '0;
  endsequence

  sequence s_last_out;
    out_fire && out_eop;
  endsequence

  apb_no_wait_a: assert property (apb_access |-> pready)
    else $error("access cycle without pready");

  unmapped_err_a: assert property (apb_access && !mapped |-> pslverr)
    else $error("unmapped access not flagged");

  numerr_zero_a: assert property (
    apb_access && hit_numerr |-> prdata == 32'h0000_0000 && numerr == 8'h00)
    else $error("error count not zero");

  reset_metric_a: assert property (
    first_cycle |-> metric[0] == '0 && metric[1] == METRIC_MAX
                    && metric[2] == METRIC_MAX && metric[3] == METRIC_MAX)
    else $error("metrics wrong after reset");

  start_load_a: assert property (
    accept && in_sop && !continuous && HYBRID |->
      base_metric[metric_start_state[1:0]] == metric_start_value
      && base_metric[metric_start_state[1:0] ^ 2'h1] == '0
      && base_metric[metric_start_state[1:0] ^ 2'h2] == '0
      && base_metric[metric_start_state[1:0] ^ 2'h3] == '0)
    else $error("start metrics not loaded");

  zero_start_a: assert property (
    accept && in_sop && !continuous && !HYBRID |->
      base_metric == {{MW{1'b0}}, {MW{1'b0}}, {MW{1'b0}}, INIT_VALUE})
    else $error("fixed start not in state zero");

  carry_over_a: assert property (
    accept && continuous |-> base_metric == metric)
    else $error("metrics reset in continuous mode");

  end_state_a: assert property (
    s_block_end ##0 tb_kind |=>
      phase == tcm_pkg::TCM_TRACE && tb_state == 2'($past(traceback_end_state)))
    else $error("traceback not from end state");

  trace_exit_a: assert property (s_trace_done |=> out_valid && optr == '0 && !in_ready)
    else $error("traceback did not hand over to output");

  trace_bound_a: assert property (s_block_end |=> !in_ready ##[0:DEPTH] out_valid)
    else $error("traceback too long");

  block_close_a: assert property (s_last_out |=> in_ready && !out_valid && fill == '0)
    else $error("block not closed after last bit");

  metric_hold_a: assert property (!accept |=> metric == $past(metric))
    else $error("metrics moved without a symbol");

endmodule

// ===== bench/tcm_demap_model.sv
module tcm_demap_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Encoder control
  input wire logic load,
  input wire logic [1:0] load_state,
  input wire logic info_bit,
  input wire logic [2:0] poly,
  input wire logic [1:0] noise,
  // Handshake seen at the decoder
  input wire logic in_valid,
  input wire logic in_ready,
  // Branch metrics toward the decoder
  output tcm_pkg::tcm_symbol_type sym
);
  // Encoder state, newest bit on top
  logic [1:0] enc_state;
  // Four metrics before packing
  logic [15:0] packed_m;
  // Coded bit from taps {input,s1,s0}; one bit coded, one left out
  wire coded = ^(poly & {info_bit, enc_state});
  // Both polynomials equal, so the coded pair repeats one bit
  wire [1:0] subset = {coded, coded};
  // Near point close, the rest near the radius
  wire [3:0] near_dist = {2'b00, noise};
  wire [3:0] far_dist = {2'b11, noise};

  // Inverted distances, metric three in the top field
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      packed_m[i*4 +: 4] = ~((subset == 2'(i)) ? near_dist : far_dist);
    end
  end
  assign sym = packed_m;

  // Encoder advances on each accepted symbol
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_state <= 2'h0;
    end else if (load) begin
      enc_state <= load_state;
    end else if (in_valid && in_ready) begin
      enc_state <= {info_bit, enc_state[1]};
    end
  end
endmodule

// ===== bench/tcm_trellis_decode_init_bench.sv
`include "tcm_regs.svh"

module tcm_trellis_decode_init_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short blocks keep the run brief
  localparam int DEPTH = 16;
  // Equal taps keep the subset order unambiguous
  localparam logic [31:0] POLY_WORD = 32'h0000_0707;
  // Clock, reset and APB
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  // Symbol stream and block settings
  logic in_valid, in_ready, in_sop, in_eop, load, info_bit;
  logic [1:0] load_state, noise;
  logic [3:0] traceback_end_state, metric_start_state;
  logic [11:0] metric_start_value;
  tcm_pkg::tcm_symbol_type soft_symbol_in;
  // Decoded side
  logic out_valid, out_ready, out_bit, out_eop;
  logic [7:0] numerr;
  // Bookkeeping
  int num_errors, comparisons;
  logic sent [DEPTH];
  logic [31:0] rd;
  logic rd_err;
  logic [1:0] start_st; // Encoder start state of the last block
  logic [1:0] sector [DEPTH]; // Subset the demapper marked near, per symbol

  tcm_trellis_decoder #(.MW(12), .DEPTH(DEPTH), .HYBRID(1'b1)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_sop(in_sop), .in_eop(in_eop),
    .soft_symbol_in(soft_symbol_in), .traceback_end_state(traceback_end_state),
    .metric_start_state(metric_start_state), .metric_start_value(metric_start_value),
    .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit), .out_eop(out_eop),
    .numerr(numerr));

  tcm_demap_model far_end (
    .pclk(pclk), .presetn(presetn), .load(load), .load_state(load_state),
    .info_bit(info_bit), .poly(3'h7), .noise(noise), .in_valid(in_valid),
    .in_ready(in_ready), .sym(soft_symbol_in));

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Compare of a register or bus word
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // Compare of a single flag or bit
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // Rate one half re-encode of one decoded bit with the taps written to the decoder
  function automatic logic [1:0] reenc(input logic [1:0] s, input logic b);
    reenc = {^({b, s} & POLY_WORD[2:0]), ^({b, s} & POLY_WORD[10:8])};
  endfunction

  // APB transfer; one idle edge after so psel is never set twice at once
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One block; a full block ends without eop; tail gives a tail-biting start,
  // again resends the previous block's bits
  task automatic send_block(input int n, input bit tail, input bit again);
    logic ok;
    logic [1:0] st;
    if (!again) begin
      for (int i = 0; i < n; i++) sent[i] = 1'($urandom);
    end
    // Tail-biting: the encoder starts in the state the block will end in
    st = tail ? {sent[n-1], sent[n-2]} : 2'($urandom);
    start_st = st;
    load <= 1'b1;
    load_state <= st;
    metric_start_state <= {2'($urandom), st};
    metric_start_value <= 12'h400;
    traceback_end_state <= {2'($urandom), sent[n-1], sent[n-2]};
    @(posedge pclk);
    load <= 1'b0;
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_sop <= (i == 0);
      in_eop <= (i == n - 1) && (n < DEPTH);
      info_bit <= sent[i];
      noise <= 2'($urandom);
      do begin
        @(negedge pclk);
        ok = in_ready;
        // Only the near field has its top bit set
        sector[i] = {soft_symbol_in.bm3[3] | soft_symbol_in.bm2[3],
                     soft_symbol_in.bm3[3] | soft_symbol_in.bm1[3]};
        @(posedge pclk);
      end while (ok !== 1'b1);
    end
    in_valid <= 1'b0;
  endtask

  // Drain decoded bits with a randomly stalling sink
  task automatic get_block(input int n);
    int k;
    int t;
    logic v, b, e;
    logic [1:0] rs;
    k = 0;
    t = 0;
    rs = start_st;
    while (k < n && t < 400) begin
      out_ready <= 1'($urandom);
      @(negedge pclk);
      v = out_valid & out_ready;
      b = out_bit;
      e = out_eop;
      if (out_valid === 1'b1) check_bit(in_ready, 1'b0);
      @(posedge pclk);
      if (v === 1'b1) begin
        check_bit(b, sent[k]);
        check_bit(e, 1'(k == n - 1));
        check_word(32'(reenc(rs, b)), 32'(sector[k]));
        rs = {b, rs[1]};
        k++;
      end
      t++;
    end
    if (k < n) begin
      num_errors++;
      $display("ERROR %0t decoded bits missing", $time);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    int n;
    logic [31:0] ctrl;
    {presetn, psel, penable, pwrite, in_valid, in_sop, in_eop, load, info_bit} = '0;
    {paddr, pwdata, load_state, noise, out_ready} = '0;
    {traceback_end_state, metric_start_state, metric_start_value} = '0;
    void'($urandom(3));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and refused accesses
    apb(1'b0, `TCM_OFF_CTRL, 32'h0);
    check_word(rd, `TCM_CTRL_RESET);
    apb(1'b0, `TCM_OFF_POLY, 32'h0);
    check_word(rd, `TCM_POLY_RESET);
    apb(1'b0, `TCM_OFF_NUMERR, 32'h0);
    check_word(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check_word(rd, 32'h0);
    check_bit(rd_err, 1'b1);
    apb(1'b1, `TCM_OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, `TCM_OFF_STATUS, 32'h0);
    check_word(rd & 32'h0000_3F03, 32'h0);
    check_bit(rd_err, 1'b0);
    apb(1'b1, `TCM_OFF_POLY, POLY_WORD);
    apb(1'b0, `TCM_OFF_POLY, 32'h0);
    check_word(rd, POLY_WORD);
    // Both traceback kinds: full, random, tail-biting, then that block again
    for (int kind = 1; kind >= 0; kind--) begin
      apb(1'b1, `TCM_OFF_CTRL, 32'(kind << `TCM_CTRL_KIND));
      for (int j = 0; j < 4; j++) begin
        if (j == 3) begin
          // Second pass of the tail-biting block, metrics carried over
          ctrl = 32'(kind << `TCM_CTRL_KIND) | 32'(1 << `TCM_CTRL_CONT);
          apb(1'b1, `TCM_OFF_CTRL, ctrl);
          apb(1'b0, `TCM_OFF_CTRL, 32'h0);
          check_word(rd, ctrl);
        end else begin
          n = (j == 0) ? DEPTH : 3 + int'($urandom % (DEPTH - 3));
        end
        send_block(n, j >= 2, j == 3);
        get_block(n);
        apb(1'b0, `TCM_OFF_STATUS, 32'h0);
        check_word(rd & 32'h0000_3F03, 32'((n - 1) << `TCM_STATUS_LEN_LSB));
        check_word({24'h0, numerr}, 32'h0);
      end
    end
    wrap_up();
  end
endmodule
